// ==== hdl/asg_pkg.sv ====
package asg_pkg;
    // ****************************************************************
    // register map (word index; byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] ADDR_START = 8'h00;
    localparam logic [7:0] ADDR_BLKSIZE = 8'h01;
    localparam logic [7:0] ADDR_NUMBLK = 8'h02;
    localparam logic [7:0] ADDR_BLKSTEP = 8'h03;
    localparam logic [7:0] ADDR_STEP = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h05;
    localparam logic [7:0] ADDR_SDLY = 8'h06;
    localparam logic [7:0] ADDR_CMD = 8'h07;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PTR = 8'h09;
    localparam logic [7:0] ADDR_DATA = 8'h0A;
    localparam logic [7:0] ADDR_FIFO = 8'h0B;
    localparam logic [7:0] ADDR_MAP0 = 8'h20;
    localparam logic [7:0] ADDR_MAP_LAST = 8'h37;

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam int MODE_RUN_LSB = 0;
    localparam int MODE_DUAL_BIT = 2;
    localparam int MODE_DLY_LSB = 3;
    localparam int SDLY_EN_BIT = 5;
    localparam int DATA_AUTOINC_BIT = 8;
    localparam int NUM_OUT = 24;
    localparam int HALF_W = 12;
    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] RUN_ONESHOT = 2'h0;
    localparam logic [1:0] RUN_RESTART = 2'h1;
    localparam logic [5:0] MODE_RESET = 6'h00;
    localparam logic [5:0] SDLY_RESET = 6'h00;
    localparam logic [4:0] MAP_ZERO_LIMIT = 5'h17;
endpackage : asg_pkg

// ==== hdl/asg_fifo.sv ====
`timescale 1ns/1ps
module asg_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] head_q;
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // output word sits in a register so read data never comes from mem
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign level_o = count;
    assign out_data_o = head_q;

    // pointer and occupancy update
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage has no reset: contents are only read once written
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
        // head preloads the next word; a write into that slot bypasses
        head_q <= (push && wr_ptr == next_rd_ptr) ? in_data_i :
            mem[next_rd_ptr];
    end
endmodule : asg_fifo

// ==== hdl/asg_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - inside a block each address is the previous one plus the step.
// - after a block the next block starts at the old block start plus block step.
// - outside dual mode the programmed number of blocks of the programmed size are made, a zero counting as one.
// - each output bit is taken from the generator bit its map selects.
// - new maps wait in shadow registers and are copied on a start or restart.
// - after reset every map connects generator bit n to output bit n.
// - the host writes a pointer register then data with auto-increment set.
// - dual mode runs two independent 12-bit sequences, one per half.
// - the lower output word can lag the upper one by a programmed delay.
// - a programmed start delay postpones the sequence after a start.
// - one-shot without restart runs once then stops until a new start.
// - run mode 00 one-shot, 01 restart, 1x continuous; reset clears mode.
// - the lower word lags the upper by 0 to 7 words per the delay field.
// - start delay enable plus five-bit count delays pin, command and restart-mode starts 1 to 31; continuous reruns skip it.
// - five map bits select an input; a value above 23 forces zero.
module asg_top (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic start_i,
    output logic [asg_pkg::NUM_OUT-1:0] addr_o,
    output logic addr_valid_o,
    input wire logic addr_ready_i,
    output logic busy_o,
    output logic done_o
);
    import asg_pkg::*;

    typedef enum logic [1:0] {ASG_IDLE, ASG_WAIT, ASG_RUN} asg_state_t;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    logic [23:0] cfg_start, cfg_bsize, cfg_nblk, cfg_bstep, cfg_step;
    logic [5:0] mode, sdly;
    logic [7:0] ptr;
    logic [4:0] map_shadow [NUM_OUT];
    logic [4:0] map_act [NUM_OUT];
    logic sw_start;
    logic acc, wr_go, rd_go, ack;
    logic [7:0] wr_idx;
    logic [1:0] run_mode;
    logic dual, sd_en;
    logic [2:0] lo_dly;
    logic [4:0] sd_cnt;

    assign run_mode = mode[MODE_RUN_LSB +: 2];
    assign dual = mode[MODE_DUAL_BIT];
    assign lo_dly = mode[MODE_DLY_LSB +: 3];
    assign sd_en = sdly[SDLY_EN_BIT];
    assign sd_cnt = sdly[4:0];

    // one wait cycle per access, so waitrequest drops on the second edge
    assign acc = (avs_read_i || avs_write_i) && !ack;
    assign wr_go = avs_write_i && ack; // lands while waitrequest is low
    assign rd_go = avs_read_i && !ack;
    // data port writes go to the pointer target, direct writes to their own
    assign wr_idx = (avs_address_i == ADDR_DATA) ? ptr : avs_address_i;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cfg_start <= '0;
            cfg_bsize <= '0;
            cfg_nblk <= '0;
            cfg_bstep <= '0;
            cfg_step <= '0;
            mode <= MODE_RESET;
            sdly <= SDLY_RESET;
            ptr <= '0;
            sw_start <= 1'b0;
        end else begin
            sw_start <= wr_go && avs_address_i == ADDR_CMD;
            if (wr_go && avs_address_i == ADDR_PTR) begin
                ptr <= avs_writedata_i[7:0];
            end
            if (wr_go && avs_address_i == ADDR_DATA &&
                avs_writedata_i[DATA_AUTOINC_BIT]) begin
                ptr <= ptr + 8'h01;
            end
            if (wr_go) begin
                case (wr_idx)
                    ADDR_START: cfg_start <= avs_writedata_i[23:0];
                    ADDR_BLKSIZE: cfg_bsize <= avs_writedata_i[23:0];
                    ADDR_NUMBLK: cfg_nblk <= avs_writedata_i[23:0];
                    ADDR_BLKSTEP: cfg_bstep <= avs_writedata_i[23:0];
                    ADDR_STEP: cfg_step <= avs_writedata_i[23:0];
                    ADDR_MODE: mode <= avs_writedata_i[5:0];
                    ADDR_SDLY: sdly <= avs_writedata_i[5:0];
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // crosspoint maps: shadow written by software, active copied on start
    // ****************************************************************
    logic load_map;
    logic [23:0] gen_word;
    logic [23:0] sw_word;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_map
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    map_shadow[gi] <= 5'(gi);
                    map_act[gi] <= 5'(gi);
                end else begin
                    if (wr_go && wr_idx == ADDR_MAP0 + 8'(gi)) begin
                        map_shadow[gi] <= avs_writedata_i[4:0];
                    end
                    if (load_map) begin
                        map_act[gi] <= map_shadow[gi];
                    end
                end
            end
            // out-of-range select reads zero rather than wrapping
            assign sw_word[gi] = (map_act[gi] > MAP_ZERO_LIMIT) ? 1'b0 :
                gen_word[map_act[gi]];
        end
    endgenerate

    // ****************************************************************
    // start delay and sequence engine
    // ****************************************************************
    asg_state_t state, next_state;
    logic [4:0] dcnt, next_dcnt;
    logic [23:0] cur, next_cur, bstart, next_bstart;
    logic [23:0] icnt, next_icnt, bcnt, next_bcnt;
    logic [11:0] cur2, next_cur2, bst2, next_bst2;
    logic [11:0] ic2, next_ic2, bc2, next_bc2;
    logic gen_valid, next_gen_valid, fin, next_fin;
    logic fifo_ready, trig, last_a, last_b, blk_a, blk_b, adv;
    logic [5:0] fifo_level;

    assign trig = start_i || sw_start;
    // back-pressure stalls; a word still in flight claims the last slot
    assign adv = state == ASG_RUN && fifo_ready &&
        !(gen_valid && fifo_level == 6'(FIFO_DEPTH - 1));
    // dual mode: lower half counts on its own with the low 12 bits of config
    assign blk_a = dual ? (icnt[11:0] <= 12'h001) : (icnt <= 24'h000001);
    assign last_a = blk_a &&
        (dual ? (bcnt[11:0] <= 12'h001) : (bcnt <= 24'h000001));
    assign blk_b = ic2 <= 12'h001;
    assign last_b = blk_b && bc2 <= 12'h001;
    assign gen_word = dual ? {cur2, cur[11:0]} : cur;

    always_comb begin
        next_state = state;
        next_dcnt = dcnt;
        next_cur = cur;
        next_bstart = bstart;
        next_icnt = icnt;
        next_bcnt = bcnt;
        next_cur2 = cur2;
        next_bst2 = bst2;
        next_ic2 = ic2;
        next_bc2 = bc2;
        next_gen_valid = 1'b0;
        next_fin = 1'b0;
        load_map = 1'b0;
        case (state)
            ASG_IDLE: begin
                if (trig) begin
                    next_dcnt = sd_cnt;
                    next_state = (sd_en && sd_cnt != 5'h00) ?
                        ASG_WAIT : ASG_RUN;
                end
            end
            ASG_WAIT: begin
                next_dcnt = dcnt - 5'h01;
                if (dcnt == 5'h01) begin
                    next_state = ASG_RUN;
                end
            end
            ASG_RUN: ;
            default: next_state = ASG_IDLE;
        endcase
        // entering run: load counters and copy maps
        if (next_state == ASG_RUN && state != ASG_RUN) begin
            load_map = 1'b1;
            next_cur = cfg_start;
            next_bstart = cfg_start;
            next_icnt = cfg_bsize;
            next_bcnt = cfg_nblk;
            next_cur2 = cfg_start[23:12];
            next_bst2 = cfg_start[23:12];
            next_ic2 = cfg_bsize[23:12];
            next_bc2 = cfg_nblk[23:12];
        end else if (adv) begin
            next_gen_valid = 1'b1;
            if (blk_a) begin
                next_cur = bstart + cfg_bstep;
                next_bstart = bstart + cfg_bstep;
                next_icnt = cfg_bsize;
                next_bcnt = bcnt - 24'h000001;
            end else begin
                next_cur = cur + cfg_step;
                next_icnt = icnt - 24'h000001;
            end
            if (blk_b) begin
                next_cur2 = bst2 + cfg_bstep[23:12];
                next_bst2 = bst2 + cfg_bstep[23:12];
                next_ic2 = cfg_bsize[23:12];
                next_bc2 = bc2 - 12'h001;
            end else begin
                next_cur2 = cur2 + cfg_step[23:12];
                next_ic2 = ic2 - 12'h001;
            end
            if (dual ? (last_a && last_b) : last_a) begin
                next_fin = 1'b1;
                if (run_mode == RUN_ONESHOT) begin
                    next_state = ASG_IDLE;
                end else begin
                    // restart and continuous both rerun; restart honours delay
                    next_dcnt = sd_cnt;
                    next_state = (sd_en && sd_cnt != 5'h00 &&
                        run_mode == RUN_RESTART) ? ASG_WAIT : ASG_IDLE;
                    if (next_state == ASG_IDLE) begin
                        next_state = ASG_RUN;
                        load_map = 1'b1;
                        next_cur = cfg_start;
                        next_bstart = cfg_start;
                        next_icnt = cfg_bsize;
                        next_bcnt = cfg_nblk;
                        next_cur2 = cfg_start[23:12];
                        next_bst2 = cfg_start[23:12];
                        next_ic2 = cfg_bsize[23:12];
                        next_bc2 = cfg_nblk[23:12];
                    end
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= ASG_IDLE;
            dcnt <= '0;
            cur <= '0;
            bstart <= '0;
            icnt <= '0;
            bcnt <= '0;
            cur2 <= '0;
            bst2 <= '0;
            ic2 <= '0;
            bc2 <= '0;
            gen_valid <= 1'b0;
            fin <= 1'b0;
        end else begin
            state <= next_state;
            dcnt <= next_dcnt;
            cur <= next_cur;
            bstart <= next_bstart;
            icnt <= next_icnt;
            bcnt <= next_bcnt;
            cur2 <= next_cur2;
            bst2 <= next_bst2;
            ic2 <= next_ic2;
            bc2 <= next_bc2;
            gen_valid <= next_gen_valid;
            fin <= next_fin;
        end
    end

    // ****************************************************************
    // switched word, captured as generated, then lower-word delay line
    // ****************************************************************
    logic [23:0] sw_q;
    logic [11:0] lo_line [8];
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sw_q <= '0;
        end else if (adv) begin
            sw_q <= sw_word;
        end
    end

    // lower word shifts on each accepted word so the lag counts words,
    // not clocks; a stalled stream freezes both halves
    logic fifo_push;
    logic [23:0] fifo_out;
    logic fifo_valid;
    assign fifo_push = gen_valid;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 8; i++) begin
                lo_line[i] <= '0;
            end
        end else if (fifo_push) begin
            lo_line[0] <= sw_q[11:0];
            for (int i = 1; i < 8; i++) begin
                lo_line[i] <= lo_line[i-1];
            end
        end
    end

    asg_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_data_i({sw_q[23:12], (lo_dly == 3'h0) ? sw_q[11:0] :
            lo_line[lo_dly - 3'h1]}),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_valid),
        .out_ready_i(addr_ready_i || !addr_valid_o),
        .level_o(fifo_level)
    );

    // ****************************************************************
    // registered outputs and bus answer
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            addr_o <= '0;
            addr_valid_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            avs_readdata_o <= '0;
            avs_waitrequest_o <= 1'b1;
            ack <= 1'b0;
        end else begin
            if (addr_ready_i || !addr_valid_o) begin
                addr_valid_o <= fifo_valid;
                if (fifo_valid) begin
                    addr_o <= fifo_out; // held while idle
                end
            end
            busy_o <= state != ASG_IDLE;
            done_o <= fin;
            ack <= acc;
            avs_waitrequest_o <= !acc; // low only in the answer cycle
            if (rd_go) begin
                case (avs_address_i)
                    ADDR_START: avs_readdata_o <= {8'h00, cfg_start};
                    ADDR_BLKSIZE: avs_readdata_o <= {8'h00, cfg_bsize};
                    ADDR_NUMBLK: avs_readdata_o <= {8'h00, cfg_nblk};
                    ADDR_BLKSTEP: avs_readdata_o <= {8'h00, cfg_bstep};
                    ADDR_STEP: avs_readdata_o <= {8'h00, cfg_step};
                    ADDR_MODE: avs_readdata_o <= {26'h0, mode};
                    ADDR_SDLY: avs_readdata_o <= {26'h0, sdly};
                    ADDR_STATUS: avs_readdata_o <= {30'h0,
                        state == ASG_WAIT, state != ASG_IDLE};
                    ADDR_PTR: avs_readdata_o <= {24'h0, ptr};
                    ADDR_FIFO: avs_readdata_o <= {26'h0, fifo_level};
                    default: avs_readdata_o <= (avs_address_i >= ADDR_MAP0
                        && avs_address_i <= ADDR_MAP_LAST) ?
                        {27'h0, map_shadow[5'(avs_address_i - ADDR_MAP0)]} :
                        32'h0;
                endcase
            end
        end
    end
endmodule : asg_top

// ==== sim/asg_top_assertions.sv ====
`timescale 1ns/1ps
module asg_top_assertions
    import asg_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic start_i,
    input wire logic [asg_pkg::NUM_OUT-1:0] addr_o,
    input wire logic addr_valid_o,
    input wire logic addr_ready_i,
    input wire logic busy_o,
    input wire logic done_o
);
    // ********
    // port checks
    // ********
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // host access sees exactly one wait cycle
    sequence one_wait_s;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    // sink refuses a word that is on offer
    sequence stalled_s;
        addr_valid_o && !addr_ready_i;
    endsequence

    wait_write_a: assert property ($rose(avs_write_i) |-> one_wait_s)
        else $error("write not answered after one wait cycle");
    wait_read_a: assert property ($rose(avs_read_i) |-> one_wait_s)
        else $error("read not answered after one wait cycle");
    addr_hold_a: assert property (stalled_s |=> $stable(addr_o))
        else $error("address changed while refused");
    valid_hold_a: assert property (stalled_s |=> addr_valid_o)
        else $error("valid dropped while refused");
    start_busy_a: assert property (
        start_i && !busy_o |-> ##[1:2] busy_o)
        else $error("start while idle did not start");
    // a run may only end through its completion pulse
    busy_end_a: assert property (
        $fell(busy_o) |-> done_o || $past(done_o))
        else $error("busy ended without completion");
    done_cause_a: assert property (done_o |-> $past(busy_o))
        else $error("completion without a run");
    reset_clear_a: assert property ($rose(rst_n_i) |->
        addr_o == '0 && !addr_valid_o && !busy_o)
        else $error("outputs not cleared by reset");
endmodule : asg_top_assertions

bind asg_top asg_top_assertions u_asg_top_assertions (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .start_i(start_i),
    .addr_o(addr_o), .addr_valid_o(addr_valid_o),
    .addr_ready_i(addr_ready_i), .busy_o(busy_o), .done_o(done_o)
);

// ==== sim/asg_sink.sv ====
`timescale 1ns/1ps
module asg_sink (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [23:0] addr_i,
    input wire logic valid_i,
    input wire logic stall_i,
    input wire logic slow_i,
    output logic ready_o
);
    // ********
    // memory side: takes words, stalls at random
    // ********
    logic [23:0] got[$];
    // ready redrawn every cycle so stalls of any length occur
    always @(posedge clock_i) begin
        if (rst_n_i && valid_i === 1'b1 && ready_o === 1'b1)
            got.push_back(addr_i);
        ready_o <= rst_n_i && !stall_i &&
            (!slow_i || $urandom_range(1, 0) == 1);
    end
endmodule : asg_sink

// ==== sim/asg_top_tb.sv ====
`timescale 1ns/1ps
module asg_top_tb;
    import asg_pkg::*;
    localparam int LIMIT = 40000;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wait_req;
    logic start = 1'b0;
    logic [23:0] addr;
    logic vld;
    logic rdy;
    logic busy;
    logic done;
    logic stall = 1'b0;
    logic slow = 1'b1;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    int dcnt = 0;
    int d0;
    int lat;
    int t0;
    logic [31:0] rd;
    logic [23:0] exp_q[$];
    logic [4:0] map_e[24];
    logic [4:0] fft[4] = '{5'h01, 5'h02, 5'h00, 5'h1F};

    asg_top u_asg_top (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req),
        .start_i(start), .addr_o(addr), .addr_valid_o(vld),
        .addr_ready_i(rdy), .busy_o(busy), .done_o(done)
    );
    asg_sink u_asg_sink (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .valid_i(vld), .stall_i(stall), .slow_i(slow), .ready_o(rdy)
    );

    // ********
    // clock, ceiling and completion counter
    // ********
    always #25 clock_i = ~clock_i;
    // completions are counted here since short runs end before go returns
    always @(posedge clock_i) begin
        cycles++;
        if (done === 1'b1)
            dcnt++;
        if (cycles == LIMIT) begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask : cmp

    // host cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock_i);
        adr <= a;
        wdat <= d;
        wr_en <= w;
        rd_en <= !w;
        do
            @(posedge clock_i);
        while (wait_req !== 1'b0);
        rd = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask : bus

    task automatic rst();
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
    endtask : rst

    function automatic logic [23:0] remap(input logic [23:0] g);
        logic [23:0] r;
        r = '0;
        for (int j = 0; j < NUM_OUT; j++)
            if (map_e[j] <= MAP_ZERO_LIMIT)
                r[j] = g[map_e[j]];
        return r;
    endfunction : remap

    // program a sequence and work out the words it must give
    task automatic cfg(input logic [23:0] st, stp, bst, input int bs, nb,
                       input logic dual);
        logic [23:0] a;
        exp_q.delete();
        for (int b = 0; b < nb; b++)
            for (int i = 0; i < bs; i++) begin
                a = st + 24'(b) * bst + 24'(i) * stp;
                if (dual)
                    a = {st[23:12] + 12'(b * bst[23:12] + i * stp[23:12]),
                         st[11:0] + 12'(b * bst[11:0] + i * stp[11:0])};
                exp_q.push_back(a);
            end
        bus(1, ADDR_START, 32'(st));
        bus(1, ADDR_STEP, 32'(stp));
        bus(1, ADDR_BLKSTEP, 32'(bst));
        bus(1, ADDR_BLKSIZE, dual ? {8'h00, 12'(bs), 12'(bs)} : 32'(bs));
        bus(1, ADDR_NUMBLK, dual ? {8'h00, 12'(nb), 12'(nb)} : 32'(nb));
    endtask : cfg

    // start by pin or by command write, then time the first word
    task automatic go(input logic sw);
        d0 = dcnt;
        u_asg_sink.got.delete();
        if (sw) begin
            bus(1, ADDR_CMD, 32'h0);
        end else begin
            @(posedge clock_i);
            start <= 1'b1;
            @(posedge clock_i);
            start <= 1'b0;
        end
        lat = 0;
        while (vld !== 1'b1) begin
            @(posedge clock_i);
            lat++;
        end
    endtask : go

    // one-shot end: single completion, no word more or less
    task automatic fin();
        while (dcnt == d0)
            @(posedge clock_i);
        repeat (150) @(posedge clock_i);
        cmp(dcnt - d0, 1);
        cmp(u_asg_sink.got.size(), exp_q.size());
        foreach (exp_q[k])
            cmp(u_asg_sink.got[k], remap(exp_q[k]));
    endtask : fin

    task automatic reset_chk();
        for (int j = 0; j < NUM_OUT; j++) begin
            bus(0, ADDR_MAP0 + 8'(j), 32'h0);
            cmp(rd, j);
            map_e[j] = 5'(j);
        end
        bus(0, ADDR_MODE, 32'h0);
        cmp(rd, MODE_RESET);
        bus(0, ADDR_SDLY, 32'h0);
        cmp(rd, SDLY_RESET);
        bus(0, 8'h10, 32'h0);
        cmp(rd, 32'h0);
    endtask : reset_chk

    // ********
    // main sequence
    // ********
    initial begin
        void'($urandom(32'h6976));
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
        reset_chk();
        // sink stalled: buffer fills and refuses, then drains to empty
        stall <= 1'b1;
        cfg(24'd35, 24'd1, 24'd16, 8, 8, 1'b0);
        go(1'b0);
        repeat (80) @(posedge clock_i);
        bus(0, ADDR_FIFO, 32'h0);
        cmp(rd, FIFO_DEPTH);
        stall <= 1'b0;
        fin();
        bus(0, ADDR_FIFO, 32'h0);
        cmp(rd, 32'h0);
        for (int n = 0; n < 4; n++) begin
            cfg(24'($urandom), 24'($urandom_range(4)),
                24'($urandom_range(63)), $urandom_range(4, 1),
                $urandom_range(3, 1), 1'b0);
            go(n[0]);
            fin();
        end
        // stage map loaded through the auto-incrementing data port
        bus(1, ADDR_PTR, 32'(ADDR_MAP0));
        foreach (fft[j]) begin
            bus(1, ADDR_DATA, 32'h100 | 32'(fft[j]));
            map_e[j] = fft[j];
        end
        foreach (fft[j]) begin
            bus(0, ADDR_MAP0 + 8'(j), 32'h0);
            cmp(rd, 32'(fft[j]));
        end
        cfg(24'd8, 24'd1, 24'd0, 8, 1, 1'b0);
        go(1'b0);
        bus(1, ADDR_MAP0, 32'h0);
        fin();
        rst();
        reset_chk();
        cfg(24'd100, 24'd2, 24'd0, 3, 1, 1'b0);
        go(1'b0);
        t0 = lat;
        fin();
        bus(1, ADDR_SDLY, 32'h25);
        go(1'b0);
        cmp(lat - t0, 5);
        fin();
        bus(1, ADDR_SDLY, 32'h0);
        bus(1, ADDR_MODE, 32'h4);
        cfg(24'h010005, 24'h003001, 24'h010008, 2, 2, 1'b1);
        go(1'b1);
        fin();
        // repeating modes keep going until reset stops them
        for (int m = 1; m < 4; m++) begin
            bus(1, ADDR_MODE, 32'(m));
            cfg(24'h000040, 24'd4, 24'd0, 3, 1, 1'b0);
            go(1'b0);
            while (u_asg_sink.got.size() < 9)
                @(posedge clock_i);
            for (int k = 0; k < 9; k++)
                cmp(u_asg_sink.got[k], exp_q[k % 3]);
            rst();
        end
        reset_chk();
        // lower half lags by three words; the line starts from reset zeros
        bus(1, ADDR_MODE, 32'h18);
        cfg(24'h123400, 24'd1, 24'd0, 6, 1, 1'b0);
        for (int k = exp_q.size() - 1; k >= 0; k--)
            exp_q[k][11:0] = (k >= 3) ? exp_q[k-3][11:0] : 12'h000;
        go(1'b0);
        fin();
        final_report();
    end
endmodule : asg_top_tb
